// [hdl/dmem_pkg.sv]
// Constants and carrier types for the data-memory access unit.
// Assumes a single core clock and a synchronous active-low reset.
//
// What this block does
// - Lower RAM 00h-7Fh reachable by direct and indirect addressing.
// - Upper RAM 80h-FFh reachable by indirect and stack addressing, never direct.
// - Direct access above 7Fh goes to the special-function space.
// - Indirect access above 7Fh goes to upper RAM, never the SFR.
// - Stack reaches all 256 internal bytes and never extended RAM.
// - Stretch bit set makes external strobes 30 clocks instead of 6.
// - External-select bit clear, its reset state, serves internal extended_ram.
// - Size bit picks 256 bytes (0, reset) or 512 bytes internal extended_ram.
// - Internal extended_ram overlays lowest external addresses; smaller size exposes more.
// - Extended RAM is reached only by external moves via R0, or pointer.
// - Pointer moves above internal size use the bus; register moves cannot.
// - External-select bit set sends all extended_ram accesses to 64 KB external.
// - Register-pointer move drives 8-bit address muxed with data on port 0.
// - Pointer move drives high byte on port 2, low byte muxed on port 0.
// - Internal extended_ram access leaves ports 0 and 2 alone, strobes inactive.
// - Two 16-bit data pointers; select bit 0 of register A2h picks one.
// - Bit 2 of the pointer control register always reads 0.
// - Incrementing the pointer control register toggles the select bit.
// - Auxiliary register 8Eh: external select bit 1, size bit 2, reset 0.
package dmem_pkg;

  localparam logic [7:0] AUX_CONTROL_ADDR    = 8'h8E;
  localparam logic [7:0] AUX_POINTER_ADDR    = 8'hA2;
  localparam logic [7:0] PTR_LOW_ADDR        = 8'h82;
  localparam logic [7:0] PTR_HIGH_ADDR       = 8'h83;
  localparam logic [7:0] LOWER_RAM_TOP       = 8'h7F;
  localparam int         STRETCH_BIT         = 0;
  localparam int         EXT_SELECT_BIT      = 1;
  localparam int         SIZE_SELECT_BIT     = 2;
  localparam int         POINTER_SELECT_BIT  = 0;
  localparam int         ZERO_BIT            = 2;
  localparam int         FLAG_THREE_BIT      = 3;
  localparam logic [7:0] AUX_CONTROL_RESET   = 8'h00;
  localparam logic [7:0] AUX_POINTER_RESET   = 8'h00;
  localparam logic [7:0] AUX_POINTER_WMASK   = 8'h09;
  localparam logic [15:0] EXTENDED_RAM_TOP_SMALL     = 16'h00FF;
  localparam logic [15:0] EXTENDED_RAM_TOP_LARGE     = 16'h01FF;
  localparam int         EXTENDED_RAM_DEPTH          = 512;
  localparam int         IRAM_DEPTH          = 256;
  localparam int         CLK_PERIOD_NS       = 5;
  localparam int         STROBE_NORMAL_CLK   = 6;
  localparam int         STROBE_STRETCH_CLK  = 30;
  localparam int         ADDR_PHASE_CLK      = 2;
  localparam logic [4:0] STROBE_NORMAL_CNT   = 5'(STROBE_NORMAL_CLK - 1);
  localparam logic [4:0] STROBE_STRETCH_CNT  = 5'(STROBE_STRETCH_CLK - 1);
  localparam logic [1:0] ADDR_PHASE_CNT      = 2'(ADDR_PHASE_CLK - 1);

  typedef enum logic [1:0]
  {
    MODE_DIRECT,
    MODE_INDIRECT,
    MODE_STACK
  } iram_mode_t;

  typedef enum logic [2:0]
  {
    PTR_NONE,
    PTR_LOAD,
    PTR_INC,
    PTR_LOAD_LOW,
    PTR_LOAD_HIGH
  } ptr_op_t;

  typedef struct packed
  {
    logic       valid;
    logic       write;
    iram_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iram_req_t;

  typedef struct packed
  {
    logic       valid;
    logic       write;
    logic       use_pointer;
    logic [7:0] reg_addr;
    logic [7:0] wdata;
  } xmove_req_t;

  typedef struct packed
  {
    logic       valid;
    logic [7:0] data;
  } resp_t;

endpackage : dmem_pkg

// [hdl/iram_space.sv]
// Internal 256-byte RAM with address-mode steering of the upper half.
// Assumes the core keeps a request valid for one clock.
`timescale 1ns/100ps
module iram_space
(
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire dmem_pkg::iram_req_t req,
  output logic                    sfr_sel,
  output dmem_pkg::resp_t         resp
);

  logic [7:0] ram [dmem_pkg::IRAM_DEPTH];
  logic       upper;
  logic       to_sfr;

  assign upper   = req.addr > dmem_pkg::LOWER_RAM_TOP;
  assign to_sfr  = upper && (req.mode == dmem_pkg::MODE_DIRECT);
  assign sfr_sel = req.valid && to_sfr;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (req.valid && req.write && !to_sfr)
    begin
      ram[req.addr] <= req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      resp <= '0;
    end
    else
    begin
      resp.valid <= req.valid && !req.write && !to_sfr;
      resp.data  <= ram[req.addr];
    end
  end

endmodule : iram_space

// [hdl/extended_ram_store.sv]
// Internal 512-byte extended RAM array.
// Assumes the caller gates enables with its own address decode.
`timescale 1ns/100ps
module extended_ram_store
(
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [8:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);

  logic [7:0] mem [dmem_pkg::EXTENDED_RAM_DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : extended_ram_store

// [hdl/data_memory_access_unit.sv]
// Data-memory access unit: internal RAM steering, extended RAM select,
// dual data pointers and the multiplexed external bus.
// Assumes the core issues one external move at a time and waits for done.
`timescale 1ns/100ps
module data_memory_access_unit
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire dmem_pkg::iram_req_t  iram_req,
  output dmem_pkg::resp_t           iram_resp,
  output logic                      sfr_access,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic                 sfr_inc,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic [7:0]           sfr_wdata,
  output logic      [7:0]           sfr_rdata,
  input  wire dmem_pkg::ptr_op_t    ptr_op,
  input  wire logic [15:0]          ptr_load_value,
  input  wire dmem_pkg::xmove_req_t xmove_req,
  output logic                      xmove_busy,
  output dmem_pkg::resp_t           xmove_resp,
  output logic [7:0]                port_zero_out,
  output logic                      port_zero_oe,
  input  wire logic [7:0]           port_zero_in,
  output logic [7:0]                port_two_out,
  output logic                      addr_latch,
  output logic                      read_strobe_n,
  output logic                      write_strobe_n,
  output logic [15:0]               data_pointer
);

  typedef enum logic [1:0]
  {
    BUS_IDLE,
    BUS_ADDR,
    BUS_STROBE
  } bus_state_t;

  logic [7:0]  auxiliary_control;
  logic [7:0]  aux_pointer_control;
  logic [15:0] pointers [2];
  logic        pointer_select;
  logic        extended_ram_pulse_stretch;
  logic        external_extended_ram_select;
  logic        extended_ram_size_select;
  logic        sfr_sel_raw;
  logic [15:0] xaddr;
  logic [15:0] extended_ram_top;
  logic        go_internal;
  logic        go_external;
  logic [7:0]  extended_ram_rdata;
  logic        extended_ram_we;
  logic        int_pending;
  bus_state_t  bus_reg;
  logic [4:0]  count_reg;
  logic        bus_write_reg;
  logic [7:0]  bus_data_reg;

  assign extended_ram_pulse_stretch   = auxiliary_control[dmem_pkg::STRETCH_BIT];
  assign external_extended_ram_select = auxiliary_control[dmem_pkg::EXT_SELECT_BIT];
  assign extended_ram_size_select     = auxiliary_control[dmem_pkg::SIZE_SELECT_BIT];
  assign pointer_select = aux_pointer_control[dmem_pkg::POINTER_SELECT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Internal RAM and special-function space decode.
  iram_space u_iram
  (
    .clk     (clk),
    .nrst    (nrst),
    .req     (iram_req),
    .sfr_sel (sfr_sel_raw),
    .resp    (iram_resp)
  );

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sfr_access <= 1'b0;
    end
    else
    begin
      sfr_access <= sfr_sel_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Auxiliary control register.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      auxiliary_control <= dmem_pkg::AUX_CONTROL_RESET;
    end
    else if (sfr_wr && sfr_addr == dmem_pkg::AUX_CONTROL_ADDR)
    begin
      auxiliary_control <= {5'h00, sfr_wdata[2:0]};
    end
  end

  // Pointer control register: increment toggles select, bit 2 stays 0.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      aux_pointer_control <= dmem_pkg::AUX_POINTER_RESET;
    end
    else if (sfr_inc && sfr_addr == dmem_pkg::AUX_POINTER_ADDR)
    begin
      aux_pointer_control <= (aux_pointer_control + 8'h01)
                             & dmem_pkg::AUX_POINTER_WMASK;
    end
    else if (sfr_wr && sfr_addr == dmem_pkg::AUX_POINTER_ADDR)
    begin
      aux_pointer_control <= sfr_wdata & dmem_pkg::AUX_POINTER_WMASK;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sfr_rdata <= 8'h00;
    end
    else if (sfr_rd)
    begin
      case (sfr_addr)
        dmem_pkg::AUX_CONTROL_ADDR: sfr_rdata <= auxiliary_control;
        dmem_pkg::AUX_POINTER_ADDR: sfr_rdata <= aux_pointer_control;
        dmem_pkg::PTR_LOW_ADDR:  sfr_rdata <= pointers[pointer_select][7:0];
        dmem_pkg::PTR_HIGH_ADDR: sfr_rdata <= pointers[pointer_select][15:8];
        default:                 sfr_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dual data pointers; only the selected one changes.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ptr
      always_ff @(posedge clk)
      begin
        if (!nrst)
        begin
          pointers[gi] <= 16'h0000;
        end
        else if (pointer_select == 1'(gi))
        begin
          case (ptr_op)
            dmem_pkg::PTR_LOAD:      pointers[gi] <= ptr_load_value;
            dmem_pkg::PTR_INC:       pointers[gi] <= pointers[gi] + 16'h0001;
            dmem_pkg::PTR_LOAD_LOW:  pointers[gi][7:0] <= ptr_load_value[7:0];
            dmem_pkg::PTR_LOAD_HIGH:
              pointers[gi][15:8] <= ptr_load_value[15:8];
            default:                 pointers[gi] <= pointers[gi];
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      data_pointer <= 16'h0000;
    end
    else
    begin
      data_pointer <= pointers[pointer_select];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Extended RAM steering.
  assign xaddr = xmove_req.use_pointer ? pointers[pointer_select]
                                       : {8'h00, xmove_req.reg_addr};
  assign extended_ram_top = extended_ram_size_select ? dmem_pkg::EXTENDED_RAM_TOP_LARGE
                                     : dmem_pkg::EXTENDED_RAM_TOP_SMALL;
  assign go_internal = xmove_req.valid && bus_reg == BUS_IDLE
                       && !external_extended_ram_select
                       && xaddr <= extended_ram_top;
  assign go_external = xmove_req.valid && bus_reg == BUS_IDLE
                       && (external_extended_ram_select
                           || xmove_req.use_pointer);
  assign extended_ram_we = go_internal && xmove_req.write;

  extended_ram_store u_extended_ram
  (
    .clk   (clk),
    .we    (extended_ram_we),
    .addr  (xaddr[8:0]),
    .wdata (xmove_req.wdata),
    .rdata (extended_ram_rdata)
  );

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      int_pending <= 1'b0;
    end
    else
    begin
      int_pending <= go_internal && !xmove_req.write;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External multiplexed bus sequencer.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bus_reg       <= BUS_IDLE;
      count_reg     <= 5'h00;
      bus_write_reg <= 1'b0;
      bus_data_reg  <= 8'h00;
    end
    else
    begin
      case (bus_reg)
        BUS_IDLE:
        begin
          if (go_external && !go_internal)
          begin
            bus_reg       <= BUS_ADDR;
            count_reg     <= {3'h0, dmem_pkg::ADDR_PHASE_CNT};
            bus_write_reg <= xmove_req.write;
            bus_data_reg  <= xmove_req.wdata;
          end
        end
        BUS_ADDR:
        begin
          if (count_reg == 5'h00)
          begin
            bus_reg   <= BUS_STROBE;
            count_reg <= extended_ram_pulse_stretch ? dmem_pkg::STROBE_STRETCH_CNT
                                            : dmem_pkg::STROBE_NORMAL_CNT;
          end
          else
          begin
            count_reg <= count_reg - 5'h01;
          end
        end
        BUS_STROBE:
        begin
          if (count_reg == 5'h00)
          begin
            bus_reg <= BUS_IDLE;
          end
          else
          begin
            count_reg <= count_reg - 5'h01;
          end
        end
        default: bus_reg <= BUS_IDLE;
      endcase
    end
  end

  // Pin drive: ports hold their value outside external cycles.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      port_zero_out  <= 8'h00;
      port_zero_oe   <= 1'b0;
      port_two_out   <= 8'h00;
      addr_latch     <= 1'b0;
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
    end
    else if (bus_reg == BUS_IDLE && go_external && !go_internal)
    begin
      port_zero_out <= xaddr[7:0];
      port_zero_oe  <= 1'b1;
      addr_latch    <= 1'b1;
      if (xmove_req.use_pointer)
      begin
        port_two_out <= xaddr[15:8];
      end
    end
    else if (bus_reg == BUS_ADDR && count_reg == 5'h00)
    begin
      addr_latch     <= 1'b0;
      port_zero_out  <= bus_data_reg;
      port_zero_oe   <= bus_write_reg;
      read_strobe_n  <= bus_write_reg;
      write_strobe_n <= !bus_write_reg;
    end
    else if (bus_reg == BUS_STROBE && count_reg == 5'h00)
    begin
      port_zero_oe   <= 1'b0;
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
    end
    else
    begin
      addr_latch <= (bus_reg == BUS_ADDR) ? addr_latch : 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      xmove_resp <= '0;
      xmove_busy <= 1'b0;
    end
    else
    begin
      xmove_busy <= (bus_reg != BUS_IDLE) || (go_external && !go_internal);
      if (int_pending)
      begin
        xmove_resp <= '{valid: 1'b1, data: extended_ram_rdata};
      end
      else if (bus_reg == BUS_STROBE && count_reg == 5'h00)
      begin
        xmove_resp <= '{valid: !bus_write_reg, data: port_zero_in};
      end
      else
      begin
        xmove_resp.valid <= 1'b0;
      end
    end
  end

endmodule : data_memory_access_unit

// [testbench/ext_mem_model.sv]
// External memory on the multiplexed port 0 / port 2 bus.
// Assumes active-low strobes that follow an address latch pulse.
`timescale 1ns/100ps
module ext_mem_model
(
  input  wire logic        clk,
  input  wire logic [7:0]  port_zero_out,
  input  wire logic [7:0]  port_two_out,
  input  wire logic        addr_latch,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [4:0]  delay,
  output logic      [7:0]  port_zero_in,
  output logic      [15:0] last_addr,
  output int               access_cnt
);
  logic [7:0] mem [65536];
  logic [4:0] wait_reg = 5'h00;
  logic       lat_q = 1'b0;
  initial
  begin
    access_cnt = 0;
    last_addr = 16'h0000;
    port_zero_in = 8'h00;
  end
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    lat_q <= addr_latch;
    if (addr_latch && !lat_q)
    begin
      last_addr <= {port_two_out, port_zero_out};
      access_cnt <= access_cnt + 1;
    end
    if (!write_strobe_n)
      mem[last_addr] <= port_zero_out;
    wait_reg <= read_strobe_n ? 5'h00 : wait_reg + 5'h01;
    // Slow device: data only after delay cycles, else a changing pattern.
    if (!read_strobe_n && wait_reg >= delay)
      port_zero_in <= mem[last_addr];
    else
      port_zero_in <= ~port_zero_in;
  end
endmodule : ext_mem_model

// [testbench/dmau_sva.sv]
// Checker for the data-memory access unit top ports.
// Assumes it is bound onto that top module.
`timescale 1ns/100ps
module dmau_sva
(
  input wire logic                clk,
  input wire logic                nrst,
  input wire dmem_pkg::iram_req_t iram_req,
  input wire dmem_pkg::resp_t     iram_resp,
  input wire logic                sfr_access,
  input wire logic                sfr_wr,
  input wire logic                sfr_rd,
  input wire logic [7:0]          sfr_addr,
  input wire logic [7:0]          sfr_wdata,
  input wire logic [7:0]          sfr_rdata,
  input wire logic                port_zero_oe,
  input wire logic                addr_latch,
  input wire logic                read_strobe_n,
  input wire logic                write_strobe_n,
  input wire logic                xmove_busy,
  input wire logic [15:0]         data_pointer
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic       stretch_reg;
  logic [4:0] low_reg;
  logic       strobe;
  logic       hi_dir;
  assign strobe = !(read_strobe_n && write_strobe_n);
  assign hi_dir = iram_req.valid && iram_req.mode == dmem_pkg::MODE_DIRECT
                  && iram_req.addr > dmem_pkg::LOWER_RAM_TOP;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      stretch_reg <= 1'b0;
    else if (sfr_wr && sfr_addr == dmem_pkg::AUX_CONTROL_ADDR)
      stretch_reg <= sfr_wdata[dmem_pkg::STRETCH_BIT];
  end
  always_ff @(posedge clk)
  begin
    if (!nrst || !strobe)
      low_reg <= 5'h00;
    else
      low_reg <= low_reg + 5'h01;
  end
  ////////////////////////////////////////
  sequence addr_phase_s;
    addr_latch && port_zero_oe ##1 addr_latch;
  endsequence
  sequence strobe_on_s;
    !addr_latch && strobe;
  endsequence
  a_direct_sfr: assert property (hi_dir |=> sfr_access)
    else $error("direct high access gave no sfr pulse");
  a_sfr_cause: assert property (sfr_access |-> $past(hi_dir))
    else $error("sfr pulse without direct high access");
  a_ram_answer: assert property
    (iram_req.valid && !iram_req.write && !hi_dir |=> iram_resp.valid)
    else $error("ram read gave no answer");
  a_addr_then_strobe: assert property
    ($rose(addr_latch) |-> addr_phase_s ##1 strobe_on_s)
    else $error("address phase not followed by strobe");
  a_strobe_width: assert property
    ($fell(strobe) |-> low_reg == (stretch_reg ? 5'h1E : 5'h06))
    else $error("strobe width wrong");
  a_read_released: assert property
    (!read_strobe_n |-> !port_zero_oe && write_strobe_n)
    else $error("port 0 driven during read strobe");
  a_write_drives: assert property (!write_strobe_n |-> port_zero_oe)
    else $error("port 0 not driven during write strobe");
  a_bus_in_cycle: assert property (strobe || addr_latch |-> xmove_busy)
    else $error("bus activity outside a bus cycle");
  a_bit_two_zero: assert property
    (sfr_rd && sfr_addr == dmem_pkg::AUX_POINTER_ADDR
     |=> !sfr_rdata[dmem_pkg::ZERO_BIT])
    else $error("pointer control bit 2 read as 1");
  a_ptr_low_read: assert property
    (sfr_rd && sfr_addr == dmem_pkg::PTR_LOW_ADDR
     |=> sfr_rdata == $past(data_pointer[7:0]))
    else $error("pointer low byte read wrong");
endmodule : dmau_sva
bind data_memory_access_unit dmau_sva i_sva
(
  .clk, .nrst, .iram_req, .iram_resp, .sfr_access, .sfr_wr, .sfr_rd,
  .sfr_addr, .sfr_wdata, .sfr_rdata, .port_zero_oe, .addr_latch,
  .read_strobe_n, .write_strobe_n, .xmove_busy, .data_pointer
);

// [testbench/data_memory_access_unit_tb_top.sv]
// Self-checking bench for the data-memory access unit.
// Assumes the checker and the memory model are compiled before it.
`timescale 1ns/100ps
module data_memory_access_unit_tb_top;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  dmem_pkg::iram_req_t  ir = '0;
  dmem_pkg::xmove_req_t xr = '0;
  dmem_pkg::ptr_op_t    ptr_op = dmem_pkg::PTR_NONE;
  logic [15:0]          plv = 16'h0000;
  logic                 sfr_wr = 1'b0;
  logic                 sfr_rd = 1'b0;
  logic                 sfr_inc = 1'b0;
  logic [7:0]           sfr_addr = 8'h00;
  logic [7:0]           sfr_wdata = 8'h00;
  logic [4:0]           delay = 5'h00;
  dmem_pkg::resp_t      iram_resp;
  dmem_pkg::resp_t      xmove_resp;
  logic                 sfr_access;
  logic [7:0]           sfr_rdata;
  logic                 xmove_busy;
  logic [7:0]           port_zero_out;
  logic                 port_zero_oe;
  logic [7:0]           port_zero_in;
  logic [7:0]           port_two_out;
  logic                 addr_latch;
  logic                 read_strobe_n;
  logic                 write_strobe_n;
  logic [15:0]          data_pointer;
  logic [15:0]          last_addr;
  int                   access_cnt;
  int                   err_total = 0;
  int                   samples_checked = 0;
  int                   cyc = 0;
  logic [7:0]           corner [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  data_memory_access_unit i_dut
  (
    .clk, .nrst, .iram_req(ir), .iram_resp, .sfr_access, .sfr_wr, .sfr_rd,
    .sfr_inc, .sfr_addr, .sfr_wdata, .sfr_rdata, .ptr_op,
    .ptr_load_value(plv), .xmove_req(xr), .xmove_busy, .xmove_resp,
    .port_zero_out, .port_zero_oe, .port_zero_in, .port_two_out,
    .addr_latch, .read_strobe_n, .write_strobe_n, .data_pointer
  );
  ext_mem_model i_mem
  (
    .clk, .port_zero_out, .port_two_out, .addr_latch, .read_strobe_n,
    .write_strobe_n, .delay, .port_zero_in, .last_addr, .access_cnt
  );
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [7:0] ram_exp(input logic [7:0] a, d);
    return (a > dmem_pkg::LOWER_RAM_TOP) ? d : ~d;
  endfunction : ram_exp
  task automatic sfr(input logic [1:0] op, input logic [7:0] a, d,
                     output logic [7:0] q);
    @(posedge clk);
    sfr_wr <= op == 2'h0;
    sfr_rd <= op == 2'h1;
    sfr_inc <= op == 2'h2;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    {sfr_wr, sfr_rd, sfr_inc} <= 3'h0;
    @(posedge clk);
    q = sfr_rdata;
    @(posedge clk);
  endtask : sfr
  task automatic ram(input logic w, input dmem_pkg::iram_mode_t m,
                     input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk);
    ir <= '{1'b1, w, m, a, d};
    @(posedge clk);
    ir.valid <= 1'b0;
    @(posedge clk);
    q = iram_resp.data;
  endtask : ram
  task automatic ptr(input dmem_pkg::ptr_op_t op, input logic [15:0] v);
    @(posedge clk);
    ptr_op <= op;
    plv <= v;
    @(posedge clk);
    ptr_op <= dmem_pkg::PTR_NONE;
    repeat (2) @(posedge clk);
  endtask : ptr
  task automatic xm(input logic w, p, input logic [7:0] a, d,
                    output logic [7:0] q);
    @(posedge clk);
    xr <= '{1'b1, w, p, a, d};
    @(posedge clk);
    xr.valid <= 1'b0;
    q = 8'h00;
    for (int n = 0; n < 80; n++)
    begin
      @(posedge clk);
      if (xmove_resp.valid)
        q = xmove_resp.data;
      if (n > 2 && !xmove_busy)
        break;
    end
  endtask : xm
  ////////////////////////////////////////
  initial
  begin
    logic [7:0]  q;
    logic [7:0]  d;
    logic [7:0]  e;
    logic [7:0]  a;
    logic [15:0] w;
    int          n;
    void'($urandom(32'h2976));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    sfr(2'h1, dmem_pkg::AUX_CONTROL_ADDR, 8'h00, q);
    chk("aux_control", q, dmem_pkg::AUX_CONTROL_RESET);
    sfr(2'h1, dmem_pkg::AUX_POINTER_ADDR, 8'h00, q);
    chk("aux_pointer", q, dmem_pkg::AUX_POINTER_RESET);
    for (int c = 0; c < 8; c++)
    begin
      a = (c < 4) ? corner[c] : 8'($urandom);
      d = 8'($urandom);
      ram(1'b1, dmem_pkg::MODE_INDIRECT, a, d, q);
      ram(1'b1, dmem_pkg::MODE_DIRECT, a, ~d, q);
      ram(1'b0, dmem_pkg::MODE_STACK, a, 8'h00, q);
      chk("ram_read", q, ram_exp(a, d));
    end
    ptr(dmem_pkg::PTR_LOAD, 16'h1234);
    chk("pointer0", data_pointer, 16'h1234);
    sfr(2'h2, dmem_pkg::AUX_POINTER_ADDR, 8'h00, q);
    chk("pointer1", data_pointer, 16'h0000);
    ptr(dmem_pkg::PTR_LOAD, 16'h02FF);
    ptr(dmem_pkg::PTR_INC, 16'h0000);
    chk("pointer_inc", data_pointer, 16'h0300);
    ptr(dmem_pkg::PTR_LOAD_LOW, 16'h5050);
    ptr(dmem_pkg::PTR_LOAD_HIGH, 16'h0101);
    sfr(2'h1, dmem_pkg::PTR_LOW_ADDR, 8'h00, q);
    chk("pointer_low", q, 8'h50);
    sfr(2'h1, dmem_pkg::PTR_HIGH_ADDR, 8'h00, q);
    chk("pointer_high", q, 8'h01);
    sfr(2'h0, dmem_pkg::AUX_POINTER_ADDR, 8'h08, q);
    chk("pointer0_back", data_pointer, 16'h1234);
    sfr(2'h2, dmem_pkg::AUX_POINTER_ADDR, 8'h00, q);
    sfr(2'h1, dmem_pkg::AUX_POINTER_ADDR, 8'h00, q);
    chk("select_toggle", q, 8'h09);
    chk("pointer1_back", data_pointer, 16'h0150);
    n = 0;
    d = 8'($urandom);
    e = ~d;
    xm(1'b1, 1'b0, 8'h40, d, q);
    xm(1'b0, 1'b0, 8'h40, 8'h00, q);
    chk("extended_ram_reg", q, d);
    chk("bus_idle", 16'(access_cnt), 16'(n));
    xm(1'b1, 1'b1, 8'h00, e, q);
    n++;
    chk("rollover", 16'(access_cnt), 16'(n));
    chk("bus_addr", last_addr, 16'h0150);
    chk("bus_data", i_mem.mem[16'h0150], e);
    sfr(2'h0, dmem_pkg::AUX_CONTROL_ADDR, 8'h04, q);
    xm(1'b1, 1'b1, 8'h00, d, q);
    xm(1'b0, 1'b1, 8'h00, 8'h00, q);
    chk("extended_ram_large", q, d);
    chk("bus_quiet", 16'(access_cnt), 16'(n));
    sfr(2'h0, dmem_pkg::AUX_CONTROL_ADDR, 8'h00, q);
    xm(1'b0, 1'b1, 8'h00, 8'h00, q);
    n++;
    chk("extended_ram_exposed", q, e);
    delay <= 5'h14;
    sfr(2'h0, dmem_pkg::AUX_CONTROL_ADDR, 8'h03, q);
    xm(1'b1, 1'b0, 8'h40, e, q);
    n++;
    chk("page_addr", last_addr[7:0], 8'h40);
    for (int c = 0; c < 3; c++)
    begin
      w = 16'($urandom);
      d = 8'($urandom);
      ptr(dmem_pkg::PTR_LOAD, w);
      xm(1'b1, 1'b1, 8'h00, d, q);
      xm(1'b0, 1'b1, 8'h00, 8'h00, q);
      n += 2;
      chk("far_read", q, d);
      chk("far_addr", last_addr, w);
    end
    chk("accesses", 16'(access_cnt), 16'(n));
    summarize();
  end
endmodule : data_memory_access_unit_tb_top
